/* File: src/dchbp_pkg.sv */
// Shared constants of the dual controller bus port
package dchbp_pkg;
  // Port select codes on the two address lines
  localparam logic [1:0] DCHBP_SEL_HC_DATA = 2'h0;
  localparam logic [1:0] DCHBP_SEL_HC_CMD = 2'h1;
  localparam logic [1:0] DCHBP_SEL_DC_DATA = 2'h2;
  localparam logic [1:0] DCHBP_SEL_DC_CMD = 2'h3;
  // Width of the shared data bus
  localparam int DCHBP_DW = 16;
  // Core clock period
  localparam int DCHBP_CLK_NS = 40;
  // Request withdrawal after grant or end of transfer, longest
  localparam int DCHBP_REQ_OFF_NS = 40;
  localparam int DCHBP_REQ_OFF_CYC = DCHBP_REQ_OFF_NS / DCHBP_CLK_NS;
  // Least access cycle and least re-request spacing
  localparam int DCHBP_CYCLE_NS = 180;
  localparam int DCHBP_CYCLE_CYC =
    (DCHBP_CYCLE_NS + DCHBP_CLK_NS - 1) / DCHBP_CLK_NS;
  // Host access phases, in cycles
  localparam int DCHBP_STROBE_CYC = 2;
  localparam int DCHBP_HOLD_CYC = 1;
  localparam int DCHBP_GAP_CYC =
    DCHBP_CYCLE_CYC - DCHBP_STROBE_CYC - DCHBP_HOLD_CYC;
  // Counter loads, sized for 3-bit counters
  localparam logic [2:0] DCHBP_REARM_LOAD = 3'(DCHBP_CYCLE_CYC);
  localparam logic [2:0] DCHBP_STROBE_LOAD = 3'(DCHBP_STROBE_CYC - 1);
  localparam logic [2:0] DCHBP_GAP_LOAD = 3'(DCHBP_GAP_CYC - 1);
  localparam logic [2:0] DCHBP_CNT_ZERO = 3'h0;
  localparam logic [2:0] DCHBP_CNT_ONE = 3'h1;
  // Idle value of the data bus when nobody drives it
  localparam logic [15:0] DCHBP_BUS_IDLE = 16'h0000;
endpackage

/* File: src/dchbp_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Pins between the processor side and the controller chip
interface dchbp_bus_if;
  logic cs_n; // Chip select, active low
  logic rd_n; // Read strobe, active low
  logic wr_n; // Store strobe, active low
  logic [1:0] addr; // Port select lines
  logic [15:0] host_data; // Processor drive value
  logic host_oe; // Processor drives the bus
  logic [15:0] dev_data; // Chip drive value
  logic dev_oe; // Chip drives the bus
  logic [15:0] parallel_data_bus; // Resolved bus level
  logic host_dma_request; // Programmable level
  logic host_dma_grant; // Programmable level
  logic device_dma_request; // Programmable level
  logic device_dma_grant; // Programmable level
  logic end_of_transfer_in; // Programmable level
  logic host_irq_line; // Programmable level and polarity
  logic device_irq_line; // Programmable level and polarity
  logic chip_reset_n; // Chip reset pin, active low

  // Chip wins a clash; an undriven bus reads as zero
  assign parallel_data_bus = dev_oe ? dev_data :
    (host_oe ? host_data : dchbp_pkg::DCHBP_BUS_IDLE);

  modport dev (
    input cs_n, rd_n, wr_n, addr, parallel_data_bus,
    input host_dma_grant, device_dma_grant, end_of_transfer_in,
    input chip_reset_n,
    output dev_data, dev_oe, host_dma_request, device_dma_request,
    output host_irq_line, device_irq_line
  );
  modport host (
    input parallel_data_bus, host_dma_request, device_dma_request,
    input host_irq_line, device_irq_line,
    output cs_n, rd_n, wr_n, addr, host_data, host_oe,
    output host_dma_grant, device_dma_grant, end_of_transfer_in,
    output chip_reset_n
  );
endinterface
`default_nettype wire

/* File: src/dchbp_chip_end.sv */
// Notes on behaviour
// - A1 low: host data or command port
// - A1 high: device data or command port
// - Shared 16-bit little-endian data bus
// - Strobes ignored while chip select high and no DMA grant active
// - One read/store strobe pair serves both
// - Two DMA channels, programmable active level
// - Two interrupt lines, level/edge, polarity
// - Reset pin low holds logic reset
// - End needs grant, strobe, end input
// - Grant-only mode: grant frames each device channel transfer
// - Withdraw host request after grant, device request after grant and strobe
// - End input polarity is programmable
// - Burst: end of transfer drops request
`timescale 1ns/10ps
`default_nettype none
module dchbp_chip_end (
  input wire logic core_clk_in,
  input wire logic reset_in,
  dchbp_bus_if.dev bus_io,
  input wire logic [3:0][15:0] rd_word_in,
  input wire logic hc_dma_want_in,
  input wire logic dc_dma_want_in,
  input wire logic hc_dma_read_in,
  input wire logic dc_dma_read_in,
  input wire logic host_dma_high_in,
  input wire logic device_dma_high_in,
  input wire logic eot_high_in,
  input wire logic ack_only_in,
  input wire logic burst_in,
  input wire logic [1:0] irq_event_in,
  input wire logic [1:0] irq_edge_in,
  input wire logic [1:0] irq_high_in,
  output logic wr_valid_out,
  output logic [1:0] wr_sel_out,
  output logic [15:0] wr_data_out,
  output logic rd_valid_out,
  output logic [1:0] rd_sel_out,
  output logic eot_seen_out
);
  // Whole state of the chip end
  typedef struct packed {
    logic wr_n_q; // Store strobe, last cycle
    logic dg_q; // Device grant, last cycle
    logic hreq_q; // Host channel request, logical
    logic dreq_q; // Device channel request, logical
    logic [2:0] hgap_q; // Host channel re-request spacing
    logic [2:0] dgap_q; // Device channel re-request spacing
    logic hreq_line_q; // Host request pin level
    logic dreq_line_q; // Device request pin level
    logic [15:0] data_q; // Bus drive value
    logic oe_q; // Bus drive enable
    logic [1:0] ev_q; // Interrupt sources, last cycle
    logic [1:0] irq_line_q; // Interrupt pin levels
    logic wr_valid_q; // Write delivered
    logic [1:0] wr_sel_q; // Write target port
    logic [15:0] wr_data_q; // Write word
    logic rd_valid_q; // Read started
    logic [1:0] rd_sel_q; // Read source port
    logic eot_q; // End of transfer seen
  } dchbp_chip_state_t;

  dchbp_chip_state_t q; // Registered state
  dchbp_chip_state_t d; // Next state

  logic sel; // Chip selected
  logic strobe; // Either strobe low
  logic wr_edge; // Store strobe just released
  logic hg; // Host grant active
  logic dg; // Device grant active
  logic eot_on; // End input active
  logic eot_valid; // Qualified end of transfer
  logic dc_move; // Device channel transfer under way
  logic dc_drop; // Device channel request must fall
  logic rd_drive; // Chip must drive the bus
  logic [1:0] rd_src; // Port that feeds the bus
  logic [1:0] irq_act; // Logical interrupt state

  // Next state from pins and user side
  always_comb
  begin
    d = q;
    d.wr_valid_q = 1'b0;
    d.rd_valid_q = 1'b0;
    d.eot_q = 1'b0;
    sel = ~bus_io.cs_n;
    strobe = ~bus_io.rd_n | ~bus_io.wr_n;
    wr_edge = bus_io.wr_n & ~q.wr_n_q;
    // Grant levels follow their programmed polarity
    hg = bus_io.host_dma_grant ~^ host_dma_high_in;
    dg = bus_io.device_dma_grant ~^ device_dma_high_in;
    eot_on = bus_io.end_of_transfer_in ~^ eot_high_in;
    // Grant-only mode counts the grant itself as the strobe
    dc_move = dg & (ack_only_in | strobe);
    eot_valid = dg & strobe & eot_on;
    dc_drop = burst_in ? eot_valid : (dc_move | eot_valid);

    // Read source: I/O access first, then the DMA channels
    rd_drive = 1'b0;
    rd_src = bus_io.addr;
    if (sel & ~bus_io.rd_n)
    begin
      rd_drive = 1'b1;
      rd_src = bus_io.addr;
    end
    else if (hg & hc_dma_read_in & ~bus_io.rd_n)
    begin
      rd_drive = 1'b1;
      rd_src = dchbp_pkg::DCHBP_SEL_HC_DATA;
    end
    else if (dg & dc_dma_read_in & (ack_only_in | ~bus_io.rd_n))
    begin
      rd_drive = 1'b1;
      rd_src = dchbp_pkg::DCHBP_SEL_DC_DATA;
    end
    // Whole word driven; low byte on the low lanes
    d.oe_q = rd_drive;
    if (rd_drive)
    begin
      d.data_q = rd_word_in[rd_src];
    end
    // One read report per drive phase
    if (rd_drive & ~q.oe_q)
    begin
      d.rd_valid_q = 1'b1;
      d.rd_sel_q = rd_src;
    end

    // Writes land on the release of the store strobe, or of the grant in grant-only mode
    if (wr_edge & sel)
    begin
      d.wr_valid_q = 1'b1;
      d.wr_sel_q = bus_io.addr;
      d.wr_data_q = bus_io.parallel_data_bus;
    end
    else if (wr_edge & hg & ~hc_dma_read_in)
    begin
      d.wr_valid_q = 1'b1;
      d.wr_sel_q = dchbp_pkg::DCHBP_SEL_HC_DATA;
      d.wr_data_q = bus_io.parallel_data_bus;
    end
    else if (~dc_dma_read_in &
             ((wr_edge & dg & ~ack_only_in) |
              (ack_only_in & ~dg & q.dg_q)))
    begin
      // Grant-only writes land on the grant release
      d.wr_valid_q = 1'b1;
      d.wr_sel_q = dchbp_pkg::DCHBP_SEL_DC_DATA;
      d.wr_data_q = bus_io.parallel_data_bus;
    end
    d.wr_n_q = bus_io.wr_n;
    d.dg_q = dg;
    d.eot_q = eot_valid;

    // Host channel: grant withdraws the request next edge
    if (q.hreq_q)
    begin
      if (hg | ~hc_dma_want_in)
      begin
        d.hreq_q = 1'b0;
        d.hgap_q = dchbp_pkg::DCHBP_REARM_LOAD;
      end
    end
    else if (hg)
    begin
      // Spacing counts only once the grant is gone
      d.hgap_q = dchbp_pkg::DCHBP_REARM_LOAD;
    end
    else if (q.hgap_q != dchbp_pkg::DCHBP_CNT_ZERO)
    begin
      d.hgap_q = q.hgap_q - dchbp_pkg::DCHBP_CNT_ONE;
    end
    else if (hc_dma_want_in)
    begin
      d.hreq_q = 1'b1;
    end

    // Device channel: drop on transfer, or on end in burst
    if (q.dreq_q)
    begin
      if (dc_drop | ~dc_dma_want_in)
      begin
        d.dreq_q = 1'b0;
        d.dgap_q = dchbp_pkg::DCHBP_REARM_LOAD;
      end
    end
    else if (dg)
    begin
      d.dgap_q = dchbp_pkg::DCHBP_REARM_LOAD;
    end
    else if (q.dgap_q != dchbp_pkg::DCHBP_CNT_ZERO)
    begin
      d.dgap_q = q.dgap_q - dchbp_pkg::DCHBP_CNT_ONE;
    end
    else if (dc_dma_want_in)
    begin
      d.dreq_q = 1'b1;
    end

    // Interrupts: level follows source, edge gives a pulse
    for (int i = 0; i < 2; i++)
    begin
      irq_act[i] = irq_edge_in[i] ? (irq_event_in[i] & ~q.ev_q[i])
                                  : irq_event_in[i];
    end
    d.ev_q = irq_event_in;

    // Reset pin low holds everything in its idle state
    if (~bus_io.chip_reset_n)
    begin
      d = '0;
      irq_act = 2'h0;
    end
    // Pins take the programmed polarity of the idle or active state
    d.hreq_line_q = d.hreq_q ~^ host_dma_high_in;
    d.dreq_line_q = d.dreq_q ~^ device_dma_high_in;
    d.irq_line_q = irq_act ~^ irq_high_in;
  end

  // Single register stage; pin levels settle one edge after reset
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Pins and user outputs straight from the state
  assign bus_io.dev_data = q.data_q;
  assign bus_io.dev_oe = q.oe_q;
  assign bus_io.host_dma_request = q.hreq_line_q;
  assign bus_io.device_dma_request = q.dreq_line_q;
  assign bus_io.host_irq_line = q.irq_line_q[0];
  assign bus_io.device_irq_line = q.irq_line_q[1];
  assign wr_valid_out = q.wr_valid_q;
  assign wr_sel_out = q.wr_sel_q;
  assign wr_data_out = q.wr_data_q;
  assign rd_valid_out = q.rd_valid_q;
  assign rd_sel_out = q.rd_sel_q;
  assign eot_seen_out = q.eot_q;
endmodule
`default_nettype wire

/* File: src/dchbp_proc_end.sv */
`timescale 1ns/10ps
`default_nettype none
// Processor side: I/O accesses and a simple DMA engine
module dchbp_proc_end (
  input wire logic core_clk_in,
  input wire logic reset_in,
  dchbp_bus_if.host bus_io,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [1:0] cmd_addr_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic [1:0] dma_en_in,
  input wire logic [1:0] dma_read_in,
  input wire logic [15:0] dma_wr_data_in,
  input wire logic eot_req_in,
  input wire logic ack_only_in,
  input wire logic host_dma_high_in,
  input wire logic device_dma_high_in,
  input wire logic eot_high_in,
  input wire logic [1:0] irq_high_in,
  input wire logic chip_reset_req_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic [1:0] dma_done_out,
  output logic [1:0] irq_out
);
  // Access phases
  typedef enum logic [1:0] {
    DCHBP_IDLE = 2'b00,
    DCHBP_STROBE = 2'b01,
    DCHBP_HOLD = 2'b10,
    DCHBP_GAP = 2'b11
  } dchbp_phase_t;

  // Whole state of the processor end
  typedef struct packed {
    dchbp_phase_t ph_q; // Current phase
    logic [2:0] cnt_q; // Phase cycles left
    logic [1:0] kind_q; // Bit 0 host DMA, bit 1 device DMA
    logic rdop_q; // Access reads the chip
    logic grant_only_q; // Grant alone frames this transfer
    logic cs_n_q; // Chip select pin
    logic rd_n_q; // Read strobe pin
    logic wr_n_q; // Store strobe pin
    logic [1:0] addr_q; // Port select pins
    logic [15:0] data_q; // Drive value
    logic oe_q; // Drive enable
    logic [1:0] g_q; // Logical grants
    logic [1:0] gline_q; // Grant pin levels
    logic eot_line_q; // End pin level
    logic rst_n_q; // Chip reset pin
    logic ready_q; // Command can be taken
    logic rsp_valid_q; // Read word ready
    logic [15:0] rsp_data_q; // Read word
    logic [1:0] done_q; // DMA transfer finished
    logic [1:0] irq_q; // Logical interrupts
  } dchbp_proc_state_t;

  dchbp_proc_state_t q; // Registered state
  dchbp_proc_state_t d; // Next state
  logic [1:0] req; // Logical requests from the chip
  logic eot_act; // Logical end request

  // Next state
  always_comb
  begin
    d = q;
    d.rsp_valid_q = 1'b0;
    d.done_q = 2'h0;
    eot_act = 1'b0;
    req[0] = bus_io.host_dma_request ~^ host_dma_high_in;
    req[1] = bus_io.device_dma_request ~^ device_dma_high_in;
    d.irq_q[0] = bus_io.host_irq_line ~^ irq_high_in[0];
    d.irq_q[1] = bus_io.device_irq_line ~^ irq_high_in[1];
    d.rst_n_q = ~chip_reset_req_in;
    case (q.ph_q)
      DCHBP_IDLE:
      begin
        // Device channel first, then host channel, then commands
        if (req[1] & dma_en_in[1])
        begin
          d.kind_q = 2'h2;
          d.rdop_q = dma_read_in[1];
          d.grant_only_q = ack_only_in;
        end
        else if (req[0] & dma_en_in[0])
        begin
          d.kind_q = 2'h1;
          d.rdop_q = dma_read_in[0];
          d.grant_only_q = 1'b0;
        end
        else
        begin
          d.kind_q = 2'h0;
          d.rdop_q = ~cmd_write_in;
          d.grant_only_q = 1'b0;
        end
        if ((req & dma_en_in) != 2'h0 | cmd_valid_in)
        begin
          d.ready_q = 1'b0;
          d.ph_q = DCHBP_STROBE;
          d.cnt_q = dchbp_pkg::DCHBP_STROBE_LOAD;
          d.g_q = d.kind_q;
          // Chip select only for I/O access
          d.cs_n_q = d.kind_q != 2'h0;
          d.addr_q = cmd_addr_in;
          d.rd_n_q = ~d.rdop_q | d.grant_only_q;
          d.wr_n_q = d.rdop_q | d.grant_only_q;
          d.oe_q = ~d.rdop_q;
          d.data_q = d.kind_q == 2'h0 ? cmd_data_in : dma_wr_data_in;
          eot_act = eot_req_in & d.kind_q[1];
        end
      end
      DCHBP_STROBE:
      begin
        eot_act = eot_req_in & q.kind_q[1] & ~q.grant_only_q;
        if (q.cnt_q != dchbp_pkg::DCHBP_CNT_ZERO)
        begin
          d.cnt_q = q.cnt_q - dchbp_pkg::DCHBP_CNT_ONE;
        end
        else
        begin
          // Sample read word and release strobes
          d.rsp_valid_q = q.rdop_q;
          d.rsp_data_q = bus_io.parallel_data_bus;
          d.rd_n_q = 1'b1;
          d.wr_n_q = 1'b1;
          eot_act = 1'b0;
          if (q.grant_only_q)
          begin
            d.g_q = 2'h0;
          end
          d.ph_q = DCHBP_HOLD;
        end
      end
      DCHBP_HOLD:
      begin
        // Data and select held past the strobe release; grant too, except in grant-only mode
        d.cs_n_q = 1'b1;
        d.oe_q = 1'b0;
        d.g_q = 2'h0;
        d.done_q = q.kind_q;
        d.ph_q = DCHBP_GAP;
        d.cnt_q = dchbp_pkg::DCHBP_GAP_LOAD;
      end
      DCHBP_GAP:
      begin
        if (q.cnt_q != dchbp_pkg::DCHBP_CNT_ZERO)
        begin
          d.cnt_q = q.cnt_q - dchbp_pkg::DCHBP_CNT_ONE;
        end
        else
        begin
          d.ph_q = DCHBP_IDLE;
          d.ready_q = 1'b1;
        end
      end
      default:
      begin
        d.ph_q = DCHBP_IDLE;
      end
    endcase
    d.gline_q[0] = d.g_q[0] ~^ host_dma_high_in;
    d.gline_q[1] = d.g_q[1] ~^ device_dma_high_in;
    d.eot_line_q = eot_act ~^ eot_high_in;
  end

  // State register; strobes and select idle high in reset
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      q <= '0;
      q.cs_n_q <= 1'b1;
      q.rd_n_q <= 1'b1;
      q.wr_n_q <= 1'b1;
      q.rst_n_q <= 1'b0;
      q.ph_q <= DCHBP_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign bus_io.cs_n = q.cs_n_q;
  assign bus_io.rd_n = q.rd_n_q;
  assign bus_io.wr_n = q.wr_n_q;
  assign bus_io.addr = q.addr_q;
  assign bus_io.host_data = q.data_q;
  assign bus_io.host_oe = q.oe_q;
  assign bus_io.host_dma_grant = q.gline_q[0];
  assign bus_io.device_dma_grant = q.gline_q[1];
  assign bus_io.end_of_transfer_in = q.eot_line_q;
  assign bus_io.chip_reset_n = q.rst_n_q;
  assign cmd_ready_out = q.ready_q;
  assign rsp_valid_out = q.rsp_valid_q;
  assign rsp_data_out = q.rsp_data_q;
  assign dma_done_out = q.done_q;
  assign irq_out = q.irq_q;
endmodule
`default_nettype wire

/* File: verif/dchbp_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the pins between the processor end and the chip end
module dchbp_monitor (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] addr,
  input wire logic dev_oe,
  input wire logic host_dma_request,
  input wire logic host_dma_grant,
  input wire logic device_dma_request,
  input wire logic device_dma_grant,
  input wire logic end_of_transfer_in,
  input wire logic chip_reset_n
);
  logic [1:0] cnt_q; // Edges since reset, stops at three
  logic [1:0] cnt_d;
  logic [4:0] idle_q; // Learnt idle level of each polarity pin
  logic [4:0] idle_d;
  logic on; // Idle levels known, checks may run
  logic hreq, hgnt, dreq, dgnt, fin; // Pins seen as active high

  // Pins reach idle one edge after reset, so learn them one edge later
  always_comb
  begin
    cnt_d = (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1;
    idle_d = idle_q;
    if (cnt_q == 2'h1)
    begin
      idle_d = {host_dma_request, host_dma_grant, device_dma_request,
        device_dma_grant, end_of_transfer_in};
    end
  end

  // Helper registers
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt_q <= 2'h0;
      idle_q <= 5'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
      idle_q <= idle_d;
    end
  end

  // Polarity folded away, so one set of checks serves both settings
  // One edge more, so past samples already have idle levels folded in
  assign on = (cnt_q == 2'h3);
  assign hreq = host_dma_request ^ idle_q[4];
  assign hgnt = host_dma_grant ^ idle_q[3];
  assign dreq = device_dma_request ^ idle_q[2];
  assign dgnt = device_dma_grant ^ idle_q[1];
  assign fin = end_of_transfer_in ^ idle_q[0];

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in || !on);

  // Strobe low for two cycles, then released
  sequence s_low2(s);
    !s [*2] ##1 s;
  endsequence
  // Select held for the three cycles of an access
  sequence s_sel3;
    !cs_n [*3] ##1 cs_n;
  endsequence

  a_read_width: assert property ($fell(rd_n) |-> s_low2(rd_n))
    else $error("read strobe width wrong");
  a_write_width: assert property ($fell(wr_n) |-> s_low2(wr_n))
    else $error("store strobe width wrong");
  a_select_hold: assert property ($fell(cs_n) |-> s_sel3)
    else $error("select not held for the access");
  a_addr_steady: assert property (!cs_n && !$fell(cs_n) |-> $stable(addr))
    else $error("port select moved during access");
  a_strobe_select: assert property ($fell(rd_n) || $fell(wr_n) |->
    !cs_n || hgnt || dgnt)
    else $error("strobe without select or grant");
  a_read_drive: assert property ($fell(rd_n) && chip_reset_n |=> dev_oe)
    else $error("chip not driving on read");
  a_host_withdraw: assert property ($rose(hgnt) |=> !hreq)
    else $error("host request not withdrawn");
  a_dev_withdraw: assert property ($rose(dgnt) |=> !dreq)
    else $error("device request not withdrawn");
  a_end_drops: assert property (dgnt && fin && !(rd_n && wr_n) |=> !dreq)
    else $error("request held after end of transfer");
  a_rearm_gap: assert property ($fell(dgnt) |-> !dreq [*5])
    else $error("device request back too soon");
  a_chip_reset: assert property (!chip_reset_n && !$past(chip_reset_n) |->
    !dev_oe && !dreq && !hreq)
    else $error("chip active while held in reset");
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("wrong value %s exp %h got %h", what, exp, got); \
    end \
  end
// Both ends joined back to back, driven from their user sides
module tb;
  logic clk, rst, pol; // Pol is the level of every programmable pin
  logic cmd_valid, cmd_write, end_req, ack_only, burst, chip_rst_req;
  logic [1:0] cmd_addr, dma_en, dma_read, want, irq_event, irq_edge;
  logic [15:0] cmd_data, dma_wr_data, rsp_data, wr_data;
  logic [3:0][15:0] rd_word; // Word each port returns
  logic cmd_ready, rsp_valid, wr_valid, rd_valid, fin_seen, strobe;
  logic [1:0] dma_done, irq_out, wr_sel, rd_sel;
  int n_checks, bad_count, fin_n, rdv_n, strb_n, irq_n;

  dchbp_bus_if i_dchbp_bus_if ();
  dchbp_chip_end i_dchbp_chip_end (.core_clk_in(clk), .reset_in(rst),
    .bus_io(i_dchbp_bus_if), .rd_word_in(rd_word),
    .hc_dma_want_in(want[0]), .dc_dma_want_in(want[1]),
    .hc_dma_read_in(dma_read[0]), .dc_dma_read_in(dma_read[1]),
    .host_dma_high_in(pol), .device_dma_high_in(pol), .eot_high_in(pol),
    .ack_only_in(ack_only), .burst_in(burst), .irq_event_in(irq_event),
    .irq_edge_in(irq_edge), .irq_high_in({pol, pol}),
    .wr_valid_out(wr_valid), .wr_sel_out(wr_sel), .wr_data_out(wr_data),
    .rd_valid_out(rd_valid), .rd_sel_out(rd_sel), .eot_seen_out(fin_seen));
  dchbp_proc_end i_dchbp_proc_end (.core_clk_in(clk), .reset_in(rst),
    .bus_io(i_dchbp_bus_if), .cmd_valid_in(cmd_valid),
    .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr),
    .cmd_data_in(cmd_data), .dma_en_in(dma_en), .dma_read_in(dma_read),
    .dma_wr_data_in(dma_wr_data), .eot_req_in(end_req),
    .ack_only_in(ack_only), .host_dma_high_in(pol),
    .device_dma_high_in(pol), .eot_high_in(pol), .irq_high_in({pol, pol}),
    .chip_reset_req_in(chip_rst_req), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .dma_done_out(dma_done), .irq_out(irq_out));
  dchbp_monitor i_dchbp_monitor (.core_clk_in(clk), .reset_in(rst),
    .cs_n(i_dchbp_bus_if.cs_n), .rd_n(i_dchbp_bus_if.rd_n),
    .wr_n(i_dchbp_bus_if.wr_n), .addr(i_dchbp_bus_if.addr),
    .dev_oe(i_dchbp_bus_if.dev_oe),
    .host_dma_request(i_dchbp_bus_if.host_dma_request),
    .host_dma_grant(i_dchbp_bus_if.host_dma_grant),
    .device_dma_request(i_dchbp_bus_if.device_dma_request),
    .device_dma_grant(i_dchbp_bus_if.device_dma_grant),
    .end_of_transfer_in(i_dchbp_bus_if.end_of_transfer_in),
    .chip_reset_n(i_dchbp_bus_if.chip_reset_n));

  assign strobe = !(i_dchbp_bus_if.rd_n && i_dchbp_bus_if.wr_n);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Tallies of pulses and strobe cycles
  always @(posedge clk)
  begin
    if (fin_seen === 1'b1) fin_n++;
    if (rd_valid === 1'b1) rdv_n++;
    if (strobe === 1'b1) strb_n++;
    if (irq_out !== 2'h0) irq_n++;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic hit(input int s);
    case (s)
      0: return rsp_valid === 1'b1;
      1: return wr_valid === 1'b1;
      default: return dma_done[s-2] === 1'b1;
    endcase
  endfunction

  // Bounded wait for a completion pulse; a hang closes the run
  task automatic await(input int s);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!hit(s) && n < 50);
    if (!hit(s))
    begin
      bad_count++;
      $display("wrong value wait %0d exp 1 got 0", s);
      results();
    end
  endtask

  // One programmed access, then the gap before the next may start
  task automatic io(input logic w, input logic [1:0] a, input logic [15:0] d);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_data = d;
    cyc(1);
    cmd_valid = 1'b0;
    `CHK("busy", 1'b0, cmd_ready)
    await(w ? 1 : 0);
    cyc(4);
    `CHK("ready", 1'b1, cmd_ready)
  endtask

  // One DMA word on a channel; want dropped so no second word follows
  task automatic dma(input int ch, input logic rd);
    dma_read = {rd, rd};
    dma_en[ch] = 1'b1;
    want[ch] = 1'b1;
    await(ch + 2);
    dma_en[ch] = 1'b0;
    want[ch] = 1'b0;
    cyc(8);
  endtask

  task automatic run();
    int e0;
    // All four ports written, then each read against its rd_word value
    for (int a = 0; a < 4; a++)
    begin
      io(1'b1, 2'(a), 16'hC3A0 + 16'(a));
      `CHK("wr_sel", 2'(a), wr_sel)
      `CHK("wr_data", 16'hC3A0 + 16'(a), wr_data)
    end
    e0 = rdv_n;
    for (int a = 0; a < 4; a++)
    begin
      io(1'b0, 2'(a), 16'h0000);
      `CHK("rd_sel", 2'(a), rd_sel)
      `CHK("rsp_data", rd_word[a], rsp_data)
    end
    `CHK("rd_count", e0 + 4, rdv_n)
    // Chip held in reset: a read finds an undriven bus
    e0 = rdv_n;
    chip_rst_req = 1'b1;
    cyc(3);
    io(1'b0, 2'h2, 16'h0000);
    `CHK("rsp_idle", dchbp_pkg::DCHBP_BUS_IDLE, rsp_data)
    `CHK("rd_pulses", e0, rdv_n)
    chip_rst_req = 1'b0;
    cyc(3);
    // Host channel, one word each way
    dma(0, 1'b1);
    `CHK("hdma_rd", rd_word[0], rsp_data)
    dma_wr_data = 16'h5AF0;
    dma(0, 1'b0);
    `CHK("hdma_sel", 2'h0, wr_sel)
    `CHK("hdma_wr", 16'h5AF0, wr_data)
    // Device channel strobed, without and then with end of transfer
    e0 = fin_n;
    dma(1, 1'b1);
    `CHK("ddma_rd", rd_word[2], rsp_data)
    `CHK("end_none", e0, fin_n)
    end_req = 1'b1;
    burst = 1'b1;
    dma(1, 1'b1);
    // End pin stands through both strobe cycles, each one qualifies
    `CHK("end_one", e0 + dchbp_pkg::DCHBP_STROBE_CYC, fin_n)
    // Grant-only mode: the grant alone frames each word
    {end_req, burst, ack_only} = 3'h1;
    e0 = strb_n;
    dma_wr_data = 16'h3C69;
    dma(1, 1'b0);
    `CHK("ack_sel", 2'h2, wr_sel)
    `CHK("ack_wr", 16'h3C69, wr_data)
    rd_word[2] = 16'h7E81;
    dma(1, 1'b1);
    `CHK("ack_rd", 16'h7E81, rsp_data)
    `CHK("strobes", e0, strb_n)
    ack_only = 1'b0;
    rd_word[2] = 16'h0B11;
    // Each line in level mode, then in edge mode
    for (int m = 0; m < 4; m++)
    begin
      irq_edge = {m[1], m[1]};
      e0 = irq_n;
      irq_event[m[0]] = 1'b1;
      cyc(4);
      `CHK("irq_on", ~m[1], irq_out[m[0]])
      irq_event[m[0]] = 1'b0;
      cyc(4);
      `CHK("irq_off", 1'b0, irq_out[m[0]])
      if (m[1]) `CHK("irq_pulse", e0 + 1, irq_n)
    end
  endtask

  // Whole run once with active-low pins, once with active-high
  initial
  begin
    rst = 1'b1;
    {cmd_valid, cmd_write, end_req, ack_only, burst, chip_rst_req, pol,
      cmd_addr, dma_en, dma_read, want, irq_event, irq_edge, cmd_data,
      dma_wr_data} = '0;
    rd_word = {16'h4D33, 16'h0B11, 16'h1C22, 16'h0A00};
    for (int p = 0; p < 2; p++)
    begin
      rst = 1'b1;
      pol = p[0];
      cyc(16);
      rst = 1'b0;
      cyc(3);
      `CHK("req_idle", ~pol, i_dchbp_bus_if.device_dma_request)
      `CHK("irq_idle", ~pol, i_dchbp_bus_if.host_irq_line)
      run();
    end
    results();
  end
endmodule
`default_nettype wire
